// File: src/gpt_pin_ctrl.sv
// module: pin direction, trigger and output function control
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_ctrl
    import gpt_pkg::*;
(
    // clock and control
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // register port
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // pin
    input  wire logic       gpio_in,
    output logic            gpio_out,
    output logic            gpio_oe,
    // sources shown on the pin
    input  wire logic       irq_level,
    input  wire logic       modulator_active,
    input  wire logic       low_side_switch_on,
    input  wire logic       system_clock_tap,
    // power and start requests
    input  wire logic [1:0] power_state,
    output logic            wake_req,
    output logic            conv_start,
    output logic [1:0]      pin_conversion_kind,
    output logic [2:0]      pin_result_slot,
    output logic            seq_start,
    output logic [6:0]      seq_start_addr
);
    gpt_ctrl_t  ctrl;
    gpt_ctrl_t  next_ctrl;
    gpt_setup_t setup;
    gpt_setup_t next_setup;
    logic [6:0] seq_entry;
    logic [6:0] next_seq_entry;
    logic [7:0] next_rdata;
    gpt_ctrl_t  wr_ctrl;
    logic       wr_ctrl_ok;

    gpt_state_t state;
    gpt_state_t next_state;
    logic       pend_seq;
    logic       next_pend_seq;
    logic       next_wake;
    logic       next_conv;
    logic       next_seq;
    logic [1:0] next_kind;
    logic [2:0] next_slot;
    logic [6:0] next_saddr;
    logic       next_out;
    logic       next_oe;
    logic       lvl;
    logic       od_mode;
    logic       pin_level;
    logic       rise;
    logic       trig_en;
    logic       accept;
    logic       is_normal;

    gpt_edge_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .pin_in  (gpio_in),
        .level   (pin_level),
        .rise    (rise)
    );

    // register file
    always_comb begin
        wr_ctrl    = gpt_ctrl_t'(reg_wdata);
        wr_ctrl.rsv = 1'b0;
        wr_ctrl_ok = (wr_ctrl.dir != DIR_RSV)
                     && (wr_ctrl.isel != ISEL_RSV);
        next_ctrl      = ctrl;
        next_setup     = setup;
        next_seq_entry = seq_entry;
        next_rdata     = reg_rdata;
        if (reg_wr_en) begin
            if (reg_addr == ADDR_CTRL && wr_ctrl_ok) begin
                next_ctrl = wr_ctrl;
            end
            if (reg_addr == ADDR_SETUP) begin
                next_setup = gpt_setup_t'(reg_wdata);
                next_setup.rsv_hi  = 1'b0;
                next_setup.rsv_mid = 2'h0;
            end
            if (reg_addr == ADDR_SEQ && reg_wdata[ENTRY_HI:0] >= SEQ_MIN
                && reg_wdata[ENTRY_HI:0] <= SEQ_MAX && !reg_wdata[7]) begin
                next_seq_entry = reg_wdata[ENTRY_HI:0];
            end
        end
        if (reg_rd_en) begin
            case (reg_addr)
                ADDR_CTRL:  next_rdata = ctrl;
                ADDR_SETUP: next_rdata = setup;
                ADDR_SEQ:   next_rdata = {1'b0, seq_entry};
                default:    next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl      <= gpt_ctrl_t'(CTRL_RESET);
            setup     <= gpt_setup_t'(SETUP_RESET);
            seq_entry <= SEQ_RESET;
            reg_rdata <= 8'h00;
        end else if (ce) begin
            ctrl      <= next_ctrl;
            setup     <= next_setup;
            seq_entry <= next_seq_entry;
            reg_rdata <= next_rdata;
        end
    end

    // trigger sequencing and pin drive
    always_comb begin
        is_normal = (power_state == PWR_NORMAL);
        trig_en   = (ctrl.dir == DIR_IN)
                    && (ctrl.isel == ISEL_CONV || ctrl.isel == ISEL_SEQ);
        accept        = (state == ST_IDLE) && rise && trig_en;
        next_state    = state;
        next_pend_seq = pend_seq;
        next_wake     = 1'b0;
        next_conv     = 1'b0;
        next_seq      = 1'b0;
        next_kind     = pin_conversion_kind;
        next_slot     = pin_result_slot;
        next_saddr    = seq_start_addr;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_pend_seq = (ctrl.isel == ISEL_SEQ);
                    if (is_normal) begin
                        next_state = ST_FIRE;
                    end else begin
                        next_wake  = 1'b1;
                        next_state = ST_WAKE;
                    end
                end
            end
            ST_WAKE: begin
                if (is_normal) begin
                    next_state = ST_FIRE;
                end
            end
            ST_FIRE: begin
                next_state = ST_IDLE;
                if (pend_seq) begin
                    next_seq   = 1'b1;
                    next_saddr = seq_entry;
                end else begin
                    next_conv = 1'b1;
                    next_kind = setup.kind;
                    next_slot = setup.slot;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        case (ctrl.osel)
            OSEL_IRQ_L: lvl = ~irq_level;
            OSEL_IRQ_H: lvl = irq_level;
            OSEL_LOW:   lvl = 1'b0;
            OSEL_HIGH:  lvl = 1'b1;
            OSEL_LSW:   lvl = low_side_switch_on;
            OSEL_MOD:   lvl = modulator_active;
            OSEL_CLK:   lvl = system_clock_tap;
            default:    lvl = 1'b0;
        endcase
        od_mode = (ctrl.dir == DIR_OD) || (ctrl.osel == OSEL_LSW);
        if (ctrl.dir == DIR_IN || ctrl.dir == DIR_RSV
            || ctrl.osel == OSEL_HIZ) begin
            next_out = 1'b0;
            next_oe  = 1'b0;
        end else if (od_mode) begin
            next_out = 1'b0;
            next_oe  = ~lvl;
        end else begin
            next_out = lvl;
            next_oe  = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state               <= ST_IDLE;
            pend_seq            <= 1'b0;
            wake_req            <= 1'b0;
            conv_start          <= 1'b0;
            seq_start           <= 1'b0;
            pin_conversion_kind <= 2'h0;
            pin_result_slot     <= 3'h0;
            seq_start_addr      <= SEQ_RESET;
            gpio_out            <= 1'b0;
            gpio_oe             <= 1'b0;
        end else if (ce) begin
            state               <= next_state;
            pend_seq            <= next_pend_seq;
            wake_req            <= next_wake;
            conv_start          <= next_conv;
            seq_start           <= next_seq;
            pin_conversion_kind <= next_kind;
            pin_result_slot     <= next_slot;
            seq_start_addr      <= next_saddr;
            gpio_out            <= next_out;
            gpio_oe             <= next_oe;
        end
    end

    property p_resv_kept;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && reg_wr_en && reg_addr == ADDR_CTRL
         && reg_wdata[DIR_HI:DIR_LO] == DIR_RSV) |=> $stable(ctrl);
    endproperty
    a_resv_kept: assert property (p_resv_kept)
        else $error("reserved direction write changed control");

    property p_seq_range;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && reg_wr_en && reg_addr == ADDR_SEQ
         && reg_wdata[6:0] > SEQ_MAX) |=> $stable(seq_entry);
    endproperty
    a_seq_range: assert property (p_seq_range)
        else $error("out of range sequence entry was stored");

    property p_od_no_high;
        @(posedge ref_clk) disable iff (!rst_n)
        (gpio_oe && gpio_out && $past(ce))
        |-> ($past(ctrl.dir) == DIR_PP && $past(ctrl.osel) != OSEL_LSW);
    endproperty
    a_od_no_high: assert property (p_od_no_high)
        else $error("pin driven high outside push-pull mode");

    property p_in_no_drive;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ctrl.dir == DIR_IN) |=> !gpio_oe;
    endproperty
    a_in_no_drive: assert property (p_in_no_drive)
        else $error("pin driven while in input mode");

    property p_low_const;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ctrl.dir == DIR_PP && ctrl.osel == OSEL_LOW)
        |=> (gpio_oe && !gpio_out);
    endproperty
    a_low_const: assert property (p_low_const)
        else $error("constant low output not driven low");

    property p_wake_first;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && accept && !is_normal)
        |=> (wake_req && !conv_start && !seq_start);
    endproperty
    a_wake_first: assert property (p_wake_first)
        else $error("start issued before wake request");

    property p_fire_normal;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && accept && is_normal) ##1 ce |=> (conv_start || seq_start);
    endproperty
    a_fire_normal: assert property (p_fire_normal)
        else $error("accepted edge gave no start");

    property p_conv_setup;
        @(posedge ref_clk) disable iff (!rst_n)
        (conv_start && $past(ce))
        |-> (pin_result_slot == $past(setup.slot)
             && pin_conversion_kind == $past(setup.kind));
    endproperty
    a_conv_setup: assert property (p_conv_setup)
        else $error("pin conversion ignored setup register");

    property p_setup_no_start;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && reg_wr_en && reg_addr == ADDR_SETUP && state == ST_IDLE)
        |=> !conv_start;
    endproperty
    a_setup_no_start: assert property (p_setup_no_start)
        else $error("setup write started a conversion");
endmodule
`default_nettype wire

// File: src/gpt_pkg.sv
// package: constants, field layouts and types for the pin trigger control
`default_nettype none
package gpt_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_SETUP = 8'h06;
    localparam logic [7:0] ADDR_SEQ   = 8'h07;
    // field positions
    localparam int DIR_HI   = 7;
    localparam int DIR_LO   = 6;
    localparam int ISEL_HI  = 5;
    localparam int ISEL_LO  = 4;
    localparam int OSEL_HI  = 2;
    localparam int OSEL_LO  = 0;
    localparam int SLOT_HI  = 6;
    localparam int SLOT_LO  = 4;
    localparam int KIND_HI  = 1;
    localparam int KIND_LO  = 0;
    localparam int ENTRY_HI = 6;
    // direction codes
    localparam logic [1:0] DIR_IN  = 2'h0;
    localparam logic [1:0] DIR_RSV = 2'h1;
    localparam logic [1:0] DIR_OD  = 2'h2;
    localparam logic [1:0] DIR_PP  = 2'h3;
    // input function codes
    localparam logic [1:0] ISEL_OFF  = 2'h0;
    localparam logic [1:0] ISEL_CONV = 2'h1;
    localparam logic [1:0] ISEL_SEQ  = 2'h2;
    localparam logic [1:0] ISEL_RSV  = 2'h3;
    // output function codes
    localparam logic [2:0] OSEL_HIZ   = 3'h0;
    localparam logic [2:0] OSEL_IRQ_L = 3'h1;
    localparam logic [2:0] OSEL_IRQ_H = 3'h2;
    localparam logic [2:0] OSEL_LOW   = 3'h3;
    localparam logic [2:0] OSEL_HIGH  = 3'h4;
    localparam logic [2:0] OSEL_LSW   = 3'h5;
    localparam logic [2:0] OSEL_MOD   = 3'h6;
    localparam logic [2:0] OSEL_CLK   = 3'h7;
    // power states
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    // sequencer entry range and reset values
    localparam logic [6:0] SEQ_MIN     = 7'h3a;
    localparam logic [6:0] SEQ_MAX     = 7'h6f;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [6:0] SEQ_RESET   = 7'h3a;
    // nominal system clock shown on the pin, in hertz
    localparam int SYSCLK_HZ = 2456000;
    // least input pulse, in internal clock periods
    localparam int MIN_PULSE_CLKS = 2;

    typedef struct packed {
        logic [1:0] dir;
        logic [1:0] isel;
        logic       rsv;
        logic [2:0] osel;
    } gpt_ctrl_t;

    typedef struct packed {
        logic       rsv_hi;
        logic [2:0] slot;
        logic [1:0] rsv_mid;
        logic [1:0] kind;
    } gpt_setup_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_FIRE} gpt_state_t;
endpackage
`default_nettype wire

// File: src/gpt_edge_sync.sv
// module: two-stage synchroniser and rising edge detector for the pin
`timescale 1ns/1ps
`default_nettype none
module gpt_edge_sync
    import gpt_pkg::*;
(
    // clock and control
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // pin sample and edge
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    logic s1;
    logic s2;
    logic s3;
    logic next_s1;
    logic next_s2;
    logic next_s3;

    always_comb begin
        next_s1 = pin_in;
        next_s2 = s1;
        next_s3 = s2;
    end

    // pulses shorter than two clocks may be missed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (ce) begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end

    assign level = s2;
    assign rise  = s2 & ~s3;
endmodule
`default_nettype wire

// File: sim/gpt_pin_model.sv
// partner model: external circuit driving and sensing the pin
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_model (
    // clock
    input  wire logic ref_clk,
    // pin drive from the block
    input  wire logic gpio_out,
    input  wire logic gpio_oe,
    // pin level seen by the block
    output logic      gpio_in
);
    logic ext_val = 1'b0;
    // block drive wins, else the external level
    assign gpio_in = gpio_oe ? gpio_out : ext_val;
    // high pulse of n clocks, n of two or more
    task automatic pulse(input int n);
        @(negedge ref_clk);
        ext_val = 1'b1;
        repeat (n) @(negedge ref_clk);
        ext_val = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: sim/gpio_pin_trigger_control_test.sv
// testbench: registers, output functions and pin triggers
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_trigger_control_test;
    import gpt_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ce = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       gpio_in;
    logic       gpio_out;
    logic       gpio_oe;
    logic       irq = 1'b0;
    logic       mod = 1'b0;
    logic       lsw = 1'b0;
    logic       clk_tap = 1'b0;
    logic [1:0] pwr = 2'h0;
    logic       wake_req;
    logic       conv_start;
    logic [1:0] kind;
    logic [2:0] slot;
    logic       seq_start;
    logic [6:0] seq_addr;
    int         n_mismatch = 0;
    int         n_checks = 0;
    int         n_conv = 0;
    int         n_seq = 0;
    int         n_wake = 0;
    int         cyc = 0;

    gpt_pin_ctrl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_level(irq),
        .modulator_active(mod), .low_side_switch_on(lsw),
        .system_clock_tap(clk_tap), .power_state(pwr),
        .wake_req(wake_req), .conv_start(conv_start),
        .pin_conversion_kind(kind), .pin_result_slot(slot),
        .seq_start(seq_start), .seq_start_addr(seq_addr));
    gpt_pin_model pin (.ref_clk(ref_clk), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .gpio_in(gpio_in));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // pulse counters and hang limit
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) n_conv++;
        if (seq_start === 1'b1) n_seq++;
        if (wake_req === 1'b1) n_wake++;
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge ref_clk);
        rd_en = 1'b0;
        chk(rdata, exp);
    endtask

    task automatic clear_counts();
        n_conv = 0;
        n_seq = 0;
        n_wake = 0;
    endtask

    task automatic t_reset();
        rdchk(ADDR_CTRL, CTRL_RESET);
        rdchk(ADDR_SETUP, SETUP_RESET);
        rdchk(ADDR_SEQ, {1'b0, SEQ_RESET});
        rdchk(8'h10, 8'h00);
        chk({6'h0, gpio_oe, gpio_out}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_freeze();
        ce = 1'b0;
        wr(ADDR_CTRL, 8'hc4);
        repeat (3) @(negedge ref_clk);
        chk({6'h0, gpio_oe, gpio_out}, 8'h00);
        ce = 1'b1;
        rdchk(ADDR_CTRL, CTRL_RESET);
        $display("test clock enable done");
    endtask

    task automatic t_reserved();
        wr(ADDR_CTRL, 8'h93);
        wr(ADDR_CTRL, 8'h40);
        rdchk(ADDR_CTRL, 8'h93);
        wr(ADDR_CTRL, 8'hb0);
        rdchk(ADDR_CTRL, 8'h93);
        wr(ADDR_SEQ, 8'h39);
        rdchk(ADDR_SEQ, 8'h3a);
        wr(ADDR_SEQ, 8'h70);
        rdchk(ADDR_SEQ, 8'h3a);
        wr(ADDR_SEQ, 8'h6f);
        rdchk(ADDR_SEQ, 8'h6f);
        wr(ADDR_CTRL, 8'h00);
        $display("test reserved done");
    endtask

    task automatic t_outputs();
        logic       v;
        logic [7:0] e;
        logic [3:0] src;
        for (int s = 0; s < 4; s++) begin
            src = 4'h8 >> s;
            {irq, mod, lsw, clk_tap} = src;
            for (int o = 0; o < 8; o++) begin
                case (o)
                    1: v = ~src[3];
                    2: v = src[3];
                    3: v = 1'b0;
                    4: v = 1'b1;
                    5: v = src[1];
                    6: v = src[2];
                    default: v = src[0];
                endcase
                e = (o == 0) ? 8'h00 : (o == 5) ? {6'h0, ~v, 1'b0} : {7'h1, v};
                wr(ADDR_CTRL, 8'hc0 | 8'(o));
                repeat (3) @(negedge ref_clk);
                chk({6'h0, gpio_oe, gpio_out}, e);
                e = (o == 0) ? 8'h00 : {6'h0, ~v, 1'b0};
                wr(ADDR_CTRL, 8'h80 | 8'(o));
                repeat (3) @(negedge ref_clk);
                chk({6'h0, gpio_oe, gpio_out}, e);
                wr(ADDR_CTRL, 8'(o));
                repeat (3) @(negedge ref_clk);
                chk({6'h0, gpio_oe, gpio_out}, 8'h00);
            end
        end
        $display("test outputs done");
    endtask

    task automatic t_conv();
        wr(ADDR_CTRL, 8'h10);
        clear_counts();
        wr(ADDR_SETUP, 8'h52);
        repeat (4) @(negedge ref_clk);
        chk(8'(n_conv), 8'h00);
        pin.pulse(2);
        repeat (8) @(negedge ref_clk);
        chk(8'(n_conv), 8'h01);
        chk({6'h0, kind}, 8'h02);
        chk({5'h0, slot}, 8'h05);
        pin.pulse(7);
        repeat (8) @(negedge ref_clk);
        chk(8'(n_conv), 8'h02);
        chk(8'(n_seq), 8'h00);
        wr(ADDR_CTRL, 8'hd0);
        pin.pulse(3);
        repeat (8) @(negedge ref_clk);
        wr(ADDR_CTRL, 8'h00);
        pin.pulse(3);
        repeat (8) @(negedge ref_clk);
        chk(8'(n_conv), 8'h02);
        $display("test conversion trigger done");
    endtask

    task automatic t_seq();
        pwr = 2'h2;
        wr(ADDR_SEQ, 8'h55);
        wr(ADDR_CTRL, 8'h20);
        clear_counts();
        pin.pulse(2);
        repeat (8) @(negedge ref_clk);
        chk(8'(n_wake), 8'h01);
        chk(8'(n_seq), 8'h00);
        pwr = PWR_NORMAL;
        repeat (6) @(negedge ref_clk);
        chk(8'(n_seq), 8'h01);
        chk({1'b0, seq_addr}, 8'h55);
        chk(8'(n_conv), 8'h00);
        $display("test sequence trigger done");
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset();
        t_freeze();
        t_reserved();
        t_outputs();
        t_conv();
        t_seq();
        report_and_stop();
    end
endmodule
`default_nettype wire
